// ### ipe_pkg.sv
// Package: register map, field positions and carriers for the pin/priority block
package ipe_pkg;
  localparam int ADDR_W = 4;
  // Word offsets (byte address = 4 * index)
  localparam logic [3:0] IDX_PRIO4 = 4'h0;
  localparam logic [3:0] IDX_PRIO5 = 4'h1;
  localparam logic [3:0] IDX_RCAUSE = 4'h2;
  localparam logic [3:0] IDX_CHG_EN = 4'h3;
  localparam logic [3:0] IDX_CTL1 = 4'h4;
  localparam logic [3:0] IDX_CTL2 = 4'h5;
  localparam logic [3:0] IDX_CTL3 = 4'h6;
  localparam logic [3:0] IDX_TMR_LO = 4'h7;
  localparam logic [3:0] IDX_TMR_HI = 4'h8;
  localparam logic [3:0] IDX_MODE = 4'h9;
  localparam logic [3:0] IDX_PRIO_OUT = 4'ha;
  // Reset values
  localparam logic [7:0] RST_PRIO4 = 8'hf7;
  localparam logic [7:0] RST_PRIO5 = 8'hff;
  localparam logic [7:0] RST_RCAUSE = 8'h7c;
  localparam logic [7:0] RST_CHG_EN = 8'h00;
  localparam logic [7:0] RST_CTL1 = 8'h00;
  localparam logic [7:0] RST_CTL2 = 8'hff;
  localparam logic [7:0] RST_CTL3 = 8'hc0;
  // Writable masks
  localparam logic [7:0] MSK_PRIO4 = 8'hf7;
  localparam logic [7:0] MSK_RCAUSE_W = 8'hf3;
  localparam logic [7:0] MSK_CHG_EN = 8'hf0;
  // Field positions
  localparam int B_PRIO_ON = 7;
  localparam int B_MISMATCH = 5;
  localparam int B_RX0 = 0;
  localparam int B_GIE = 7;
  localparam int B_T0_EN = 5;
  localparam int B_P0_EN = 4;
  localparam int B_RB_EN = 3;
  localparam int B_T0_FLAG = 2;
  localparam int B_P0_FLAG = 1;
  localparam int B_RB_FLAG = 0;
  localparam int B_EDGE0 = 6;
  localparam int B_T0_PRIO = 2;
  localparam int B_P3_PRIO = 1;
  localparam int B_RB_PRIO = 0;
  localparam int B_P2_PRIO = 7;
  localparam int B_P1_PRIO = 6;
  localparam int B_P3_EN = 5;
  localparam int B_P3_FLAG = 2;
  localparam logic [1:0] CAN_MODE1 = 2'h1;
  localparam logic [1:0] TMR_HALF = 2'h0;
  localparam logic [15:0] TMR_WRAP8 = 16'h00ff;
  localparam logic [15:0] TMR_WRAP16 = 16'hffff;
  localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;

  // Register state of the block
  typedef struct packed {
    logic [7:0] prio4;
    logic [7:0] prio5;
    logic [7:0] rcause;
    logic [7:0] chg_en;
    logic [7:0] ctl1;
    logic [7:0] ctl2;
    logic [7:0] ctl3;
    logic [15:0] timer;
    logic timer16;
    logic [1:0] can_mode;
    logic [3:0] pin_s1;
    logic [3:0] pin_s2;
    logic [3:0] pin_old;
    logic [3:0] rb_s1;
    logic [3:0] rb_s2;
    logic [3:0] rb_old;
    logic started;
    logic [31:0] rdata;
    logic rvalid;
    logic hi_req;
    logic lo_req;
    logic wake;
    logic waitreq; // High except in the answer cycle
  } ipe_state_t;

  // Avalon-MM request bundle
  typedef struct packed {
    logic [ADDR_W-1:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } ipe_avm_req_t;

  // Hardware event inputs from peripherals and reset logic
  typedef struct packed {
    logic [6:0] prio4_src;
    logic [7:0] prio5_src;
    logic mismatch_rst;
    logic timer_tick;
  } ipe_evt_t;
endpackage

// ### ipe_core.sv
// Interrupt priority, reset-cause and pin-event logic with Avalon-MM slave
//
// Our own choices: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module ipe_core (
  input wire logic ref_clk, // 200 MHz clock
  input wire logic reset, // Async reset, active high
  input wire logic clk_en, // Freezes all state when low
  input wire ipe_pkg::ipe_avm_req_t avm_req, // Avalon request
  output logic [31:0] avm_readdata, // Read data
  output logic avm_readdatavalid, // Read data strobe
  output logic avm_waitrequest, // Wait request
  input wire logic [3:0] pin_in, // External event pins 0..3
  input wire logic [3:0] portb_hi, // Port B pins 7:4
  input wire ipe_pkg::ipe_evt_t evt, // Peripheral events, same clock
  output logic irq_high, // High-priority request
  output logic irq_low, // Low-priority request
  output logic wake_core // Wake from power-managed mode
);
  import ipe_pkg::*;

  ipe_state_t st_ff;
  ipe_state_t nxt_st;
  logic [3:0] pin_rise;
  logic [3:0] pin_fall;
  logic [3:0] pin_hit;
  logic [3:0] pin_en;
  logic [3:0] pin_flag;
  logic [3:0] pin_prio;
  logic rb_hit;
  logic t0_wrap;
  logic acc;
  logic wr;
  logic [7:0] wd;
  logic [7:0] prio5_rd;
  logic hi_any;
  logic lo_any;
  logic [15:0] wrap_val;

  // Bus: request seen in a wait cycle, answered one edge later; a write
  // commits only at the answer edge, where the master sees waitrequest low
  assign acc = (avm_req.read | avm_req.write) & st_ff.waitreq;
  assign wr = avm_req.write & ~st_ff.waitreq & avm_req.byteenable[0];
  assign wd = avm_req.writedata[7:0];

  // Edge detection reads only the second sync stage
  assign pin_rise = st_ff.pin_s2 & ~st_ff.pin_old;
  assign pin_fall = ~st_ff.pin_s2 & st_ff.pin_old;
  // Per-pin edge select: pin0 in ctl2 bit6, pins1..3 in bits 5..3
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_pin
      assign pin_hit[g] = st_ff.started &
        (st_ff.ctl2[B_EDGE0-g] ? pin_rise[g] : pin_fall[g]);
    end
  endgenerate

  // Pin enables, flags and priorities gathered
  assign pin_en = {st_ff.ctl3[B_P3_EN -: 3], st_ff.ctl1[B_P0_EN]};
  assign pin_flag = {st_ff.ctl3[B_P3_FLAG -: 3], st_ff.ctl1[B_P0_FLAG]};
  assign pin_prio = {st_ff.ctl2[B_P3_PRIO], st_ff.ctl3[B_P2_PRIO],
    st_ff.ctl3[B_P1_PRIO], 1'b1};

  // Port B change on any enabled pin
  assign rb_hit = st_ff.started &
    (|((st_ff.rb_s2 ^ st_ff.rb_old) & st_ff.chg_en[7:4]));

  // Timer wrap in selected width
  assign wrap_val = st_ff.timer16 ? TMR_WRAP16 : TMR_WRAP8;
  assign t0_wrap = evt.timer_tick &
    ((st_ff.timer16 ? st_ff.timer : {8'h00, st_ff.timer[7:0]}) ==
     wrap_val);

  // Receive-buffer0 bit reads zero in mode 1
  assign prio5_rd = (st_ff.can_mode == CAN_MODE1) ?
    (st_ff.prio5 & ~(8'h01 << B_RX0)) : st_ff.prio5;

  // Priority routing; without levels every source counts as high
  always_comb begin
    logic [7:0] p5;
    p5 = prio5_rd;
    hi_any = 1'b0;
    lo_any = 1'b0;
    for (int i = 0; i < 4; i++) begin
      if (pin_en[i] & pin_flag[i]) begin
        if (pin_prio[i] | ~st_ff.rcause[B_PRIO_ON]) hi_any = 1'b1;
        else lo_any = 1'b1;
      end
    end
    if (st_ff.ctl1[B_T0_EN] & st_ff.ctl1[B_T0_FLAG]) begin
      if (st_ff.ctl2[B_T0_PRIO] | ~st_ff.rcause[B_PRIO_ON]) hi_any = 1'b1;
      else lo_any = 1'b1;
    end
    if (st_ff.ctl1[B_RB_EN] & st_ff.ctl1[B_RB_FLAG]) begin
      if (st_ff.ctl2[B_RB_PRIO] | ~st_ff.rcause[B_PRIO_ON]) hi_any = 1'b1;
      else lo_any = 1'b1;
    end
    // Peripheral sources arrive pre-enabled; bit3 of prio4 unused
    for (int i = 0; i < 7; i++) begin
      if (evt.prio4_src[i]) begin
        if ((i < 3 ? st_ff.prio4[i] : st_ff.prio4[i+1]) |
            ~st_ff.rcause[B_PRIO_ON]) hi_any = 1'b1;
        else lo_any = 1'b1;
      end
    end
    for (int i = 0; i < 8; i++) begin
      if (evt.prio5_src[i]) begin
        if (p5[i] | ~st_ff.rcause[B_PRIO_ON]) hi_any = 1'b1;
        else lo_any = 1'b1;
      end
    end
  end

  // Next-state logic
  always_comb begin
    nxt_st = st_ff;
    // Two-flop synchronisers on pins
    nxt_st.pin_s1 = pin_in;
    nxt_st.pin_s2 = st_ff.pin_s1;
    nxt_st.pin_old = st_ff.pin_s2;
    nxt_st.rb_s1 = portb_hi;
    nxt_st.rb_s2 = st_ff.rb_s1;
    nxt_st.rb_old = st_ff.rb_s2;
    nxt_st.started = 1'b1; // Suppress bogus edge after reset
    nxt_st.rvalid = 1'b0;
    nxt_st.waitreq = ~acc; // Low for exactly the answer cycle
    nxt_st.rdata = RD_UNMAPPED;
    // Register reads
    if (avm_req.read & acc) begin
      nxt_st.rvalid = 1'b1;
      case (avm_req.address)
        IDX_PRIO4: nxt_st.rdata = {24'h0, st_ff.prio4 & MSK_PRIO4};
        IDX_PRIO5: nxt_st.rdata = {24'h0, prio5_rd};
        IDX_RCAUSE: nxt_st.rdata = {24'h0, st_ff.rcause};
        IDX_CHG_EN: nxt_st.rdata = {24'h0, st_ff.chg_en & MSK_CHG_EN};
        IDX_CTL1: nxt_st.rdata = {24'h0, st_ff.ctl1};
        IDX_CTL2: nxt_st.rdata = {24'h0, st_ff.ctl2};
        IDX_CTL3: nxt_st.rdata = {24'h0, st_ff.ctl3};
        IDX_TMR_LO: nxt_st.rdata = {24'h0, st_ff.timer[7:0]};
        IDX_TMR_HI: nxt_st.rdata = {24'h0, st_ff.timer[15:8]};
        IDX_MODE: nxt_st.rdata = {29'h0, st_ff.timer16, st_ff.can_mode};
        IDX_PRIO_OUT: nxt_st.rdata = {29'h0, st_ff.wake, st_ff.lo_req,
          st_ff.hi_req};
        default: nxt_st.rdata = RD_UNMAPPED;
      endcase
    end
    // Register writes
    if (wr) begin
      case (avm_req.address)
        IDX_PRIO4: nxt_st.prio4 = wd & MSK_PRIO4;
        IDX_PRIO5: nxt_st.prio5 = wd;
        IDX_RCAUSE: nxt_st.rcause = (wd & MSK_RCAUSE_W) |
          (st_ff.rcause & ~MSK_RCAUSE_W);
        IDX_CHG_EN: nxt_st.chg_en = wd & MSK_CHG_EN;
        IDX_CTL1: nxt_st.ctl1 = wd;
        IDX_CTL2: nxt_st.ctl2 = wd;
        IDX_CTL3: nxt_st.ctl3 = wd;
        IDX_TMR_LO: nxt_st.timer[7:0] = wd;
        IDX_TMR_HI: nxt_st.timer[15:8] = wd;
        IDX_MODE: begin
          nxt_st.can_mode = wd[1:0];
          nxt_st.timer16 = wd[2];
        end
        default: nxt_st.timer16 = st_ff.timer16;
      endcase
    end
    // Timer counts ticks; 8-bit mode wraps the low byte only
    if (evt.timer_tick) begin
      if (st_ff.timer16) nxt_st.timer = st_ff.timer + 16'h0001;
      else nxt_st.timer[7:0] = st_ff.timer[7:0] + 8'h01;
    end
    // Hardware sets win over software clears
    if (pin_hit[0]) nxt_st.ctl1[B_P0_FLAG] = 1'b1;
    for (int i = 1; i < 4; i++) begin
      if (pin_hit[i]) nxt_st.ctl3[i-1] = 1'b1;
    end
    if (t0_wrap) nxt_st.ctl1[B_T0_FLAG] = 1'b1;
    if (rb_hit & st_ff.ctl1[B_RB_EN])
      nxt_st.ctl1[B_RB_FLAG] = 1'b1;
    if (evt.mismatch_rst) nxt_st.rcause[B_MISMATCH] = 1'b0;
    // Requests: global enable gates vectoring, not waking
    nxt_st.hi_req = hi_any & st_ff.ctl1[B_GIE];
    nxt_st.lo_req = lo_any & st_ff.ctl1[B_GIE] &
      st_ff.rcause[B_PRIO_ON];
    nxt_st.wake = |(pin_en & pin_flag);
  end

  // State register with clock enable
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      st_ff <= '0;
      st_ff.waitreq <= 1'b1; // Busy until a request is seen
      st_ff.prio4 <= RST_PRIO4;
      st_ff.prio5 <= RST_PRIO5;
      st_ff.rcause <= RST_RCAUSE;
      st_ff.chg_en <= RST_CHG_EN;
      st_ff.ctl1 <= RST_CTL1;
      st_ff.ctl2 <= RST_CTL2;
      st_ff.ctl3 <= RST_CTL3;
    end else if (clk_en) begin
      st_ff <= nxt_st;
    end
  end

  // Outputs come from flops
  assign avm_readdata = st_ff.rdata;
  assign avm_readdatavalid = st_ff.rvalid;
  assign irq_high = st_ff.hi_req;
  assign irq_low = st_ff.lo_req;
  assign wake_core = st_ff.wake;
  // Waitrequest high when idle and in the request cycle
  assign avm_waitrequest = st_ff.waitreq;

  // Pin zero never routes to the low line
  property p_pin0_high;
    @(posedge ref_clk) disable iff (reset)
    (clk_en & pin_en[0] & pin_flag[0] & st_ff.ctl1[B_GIE]) |=> irq_high;
  endproperty
  a_pin0_high: assert property (p_pin0_high)
    else $error("pin zero not high priority");

  property p_no_low_single;
    @(posedge ref_clk) disable iff (reset)
    !st_ff.rcause[B_PRIO_ON] |=> !irq_low;
  endproperty
  a_no_low_single: assert property (p_no_low_single)
    else $error("low request without priority levels");

  property p_edge_sets;
    @(posedge ref_clk) disable iff (reset)
    (clk_en & pin_hit[0]) |=> st_ff.ctl1[B_P0_FLAG];
  endproperty
  a_edge_sets: assert property (p_edge_sets)
    else $error("pin edge did not set flag");

  property p_wrap_sets;
    @(posedge ref_clk) disable iff (reset)
    (clk_en & t0_wrap) |=> st_ff.ctl1[B_T0_FLAG];
  endproperty
  a_wrap_sets: assert property (p_wrap_sets)
    else $error("timer wrap did not set flag");

  property p_mismatch;
    @(posedge ref_clk) disable iff (reset)
    (clk_en & evt.mismatch_rst) |=> !st_ff.rcause[B_MISMATCH];
  endproperty
  a_mismatch: assert property (p_mismatch)
    else $error("mismatch flag not cleared");

  property p_ro_flags;
    @(posedge ref_clk) disable iff (reset)
    1'b1 |=> st_ff.rcause[3:2] == $past(st_ff.rcause[3:2]);
  endproperty
  a_ro_flags: assert property (p_ro_flags)
    else $error("read-only reset flags changed");

  property p_chg_low;
    @(posedge ref_clk) disable iff (reset)
    st_ff.chg_en[3:0] == 4'h0;
  endproperty
  a_chg_low: assert property (p_chg_low)
    else $error("change enable low nibble set");

  property p_mode1_zero;
    @(posedge ref_clk) disable iff (reset)
    (st_ff.can_mode == CAN_MODE1) |-> !prio5_rd[B_RX0];
  endproperty
  a_mode1_zero: assert property (p_mode1_zero)
    else $error("buffer0 priority visible in mode 1");

  // Rising select catches a rising pin zero
  property p_rise_sets;
    @(posedge ref_clk) disable iff (reset)
    (clk_en & st_ff.started & st_ff.ctl2[B_EDGE0] & st_ff.pin_s2[0] &
     !st_ff.pin_old[0]) |=> st_ff.ctl1[B_P0_FLAG];
  endproperty
  a_rise_sets: assert property (p_rise_sets)
    else $error("rising edge missed");

  property p_fall_sets;
    @(posedge ref_clk) disable iff (reset)
    (clk_en & st_ff.started & !st_ff.ctl2[B_EDGE0] & !st_ff.pin_s2[0] &
     st_ff.pin_old[0]) |=> st_ff.ctl1[B_P0_FLAG];
  endproperty
  a_fall_sets: assert property (p_fall_sets)
    else $error("falling edge missed");

  property p_pin1_sets;
    @(posedge ref_clk) disable iff (reset)
    (clk_en & pin_hit[1]) |=> pin_flag[1];
  endproperty
  a_pin1_sets: assert property (p_pin1_sets)
    else $error("pin one edge did not set flag");

  // Pin one with its priority bit clear goes to the low line
  property p_pin1_low;
    @(posedge ref_clk) disable iff (reset)
    (clk_en & st_ff.rcause[B_PRIO_ON] & st_ff.ctl1[B_GIE] & pin_en[1] &
     pin_flag[1] & !st_ff.ctl3[B_P1_PRIO]) |=> irq_low;
  endproperty
  a_pin1_low: assert property (p_pin1_low)
    else $error("pin one low priority not routed low");

  property p_t0_high;
    @(posedge ref_clk) disable iff (reset)
    (clk_en & st_ff.ctl1[B_GIE] & st_ff.ctl1[B_T0_EN] &
     st_ff.ctl1[B_T0_FLAG] & st_ff.ctl2[B_T0_PRIO]) |=> irq_high;
  endproperty
  a_t0_high: assert property (p_t0_high)
    else $error("timer wrap not routed high");

  property p_rb_high;
    @(posedge ref_clk) disable iff (reset)
    (clk_en & st_ff.ctl1[B_GIE] & st_ff.ctl1[B_RB_EN] &
     st_ff.ctl1[B_RB_FLAG] & st_ff.ctl2[B_RB_PRIO]) |=> irq_high;
  endproperty
  a_rb_high: assert property (p_rb_high)
    else $error("port change not routed high");

  // Without priority levels a peripheral always lands on the high line
  property p_single_high;
    @(posedge ref_clk) disable iff (reset)
    (clk_en & !st_ff.rcause[B_PRIO_ON] & st_ff.ctl1[B_GIE] &
     (|evt.prio4_src)) |=> irq_high;
  endproperty
  a_single_high: assert property (p_single_high)
    else $error("single level request not high");

  property p_wake;
    @(posedge ref_clk) disable iff (reset)
    (clk_en & (|(pin_en & pin_flag))) |=> wake_core;
  endproperty
  a_wake: assert property (p_wake)
    else $error("enabled pin event did not wake");

  property p_rb_sets;
    @(posedge ref_clk) disable iff (reset)
    (clk_en & st_ff.started & st_ff.ctl1[B_RB_EN] &
     (|((st_ff.rb_s2 ^ st_ff.rb_old) & st_ff.chg_en[7:4]))) |=>
    st_ff.ctl1[B_RB_FLAG];
  endproperty
  a_rb_sets: assert property (p_rb_sets)
    else $error("port change did not set flag");

  // With the change enable off only software may touch the flag
  property p_rb_quiet;
    @(posedge ref_clk) disable iff (reset)
    (clk_en & !wr & !st_ff.ctl1[B_RB_EN] & !st_ff.ctl1[B_RB_FLAG]) |=>
    !st_ff.ctl1[B_RB_FLAG];
  endproperty
  a_rb_quiet: assert property (p_rb_quiet)
    else $error("change flag set while disabled");

  property p_wrap16;
    @(posedge ref_clk) disable iff (reset)
    (clk_en & evt.timer_tick & st_ff.timer16 &
     (st_ff.timer == TMR_WRAP16)) |=> st_ff.ctl1[B_T0_FLAG];
  endproperty
  a_wrap16: assert property (p_wrap16)
    else $error("sixteen-bit wrap did not set flag");

  property p_prio4_gap;
    @(posedge ref_clk) disable iff (reset)
    (st_ff.prio4 & ~MSK_PRIO4) == 8'h00;
  endproperty
  a_prio4_gap: assert property (p_prio4_gap)
    else $error("unused priority-four bit set");

  // Mismatch flag moves only on the reset event or a software write
  property p_mm_hold;
    @(posedge ref_clk) disable iff (reset)
    (clk_en & !evt.mismatch_rst & !wr) |=>
    (st_ff.rcause[B_MISMATCH] == $past(st_ff.rcause[B_MISMATCH]));
  endproperty
  a_mm_hold: assert property (p_mm_hold)
    else $error("mismatch flag changed on its own");
endmodule
`default_nettype wire

// ### ipe_src_model.sv
// Far-side model: event pins and peripheral sources for the interrupt block
`timescale 1ns/1ps
`default_nettype none
module ipe_src_model (
  input wire logic ref_clk, // System clock
  input wire logic reset, // Async reset, active high
  input wire logic [3:0] pin_lvl, // Wanted event pin levels
  input wire logic [3:0] pb_lvl, // Wanted port B 7:4 levels
  input wire logic [6:0] src4_lvl, // Wanted priority-four requests
  input wire logic [7:0] src5_lvl, // Wanted priority-five requests
  input wire logic mm_go, // Raise for one mismatch-reset pulse
  input wire logic tick_go, // Timer ticks while high
  output logic [3:0] pin_in, // Event pins to the block
  output logic [3:0] portb_hi, // Port B pins to the block
  output var ipe_pkg::ipe_evt_t evt // Peripheral events
);
  import ipe_pkg::*;
  logic mm_ff;
  // Sources move on the clock, as real peripherals do
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pin_in <= 4'h0;
      portb_hi <= 4'h0;
      evt <= '0;
      mm_ff <= 1'b0;
    end else begin
      pin_in <= pin_lvl;
      portb_hi <= pb_lvl;
      evt.prio4_src <= src4_lvl;
      evt.prio5_src <= src5_lvl;
      evt.timer_tick <= tick_go;
      // One pulse per request, a held level would re-clear
      evt.mismatch_rst <= mm_go & ~mm_ff;
      mm_ff <= mm_go;
    end
  end
endmodule
`default_nettype wire

// ### interrupt_priority_and_pin_events_tb.sv
// Testbench: register access, priorities, pin, change and timer events
`timescale 1ns/1ps
`default_nettype none
module interrupt_priority_and_pin_events_tb;
  import ipe_pkg::*;
  logic ref_clk, reset, wreq, rvalid, irq_high, irq_low, wake_core;
  logic [31:0] rdata;
  ipe_avm_req_t req;
  ipe_evt_t evt;
  logic [3:0] pin_lvl, pb_lvl, pin_in, portb_hi;
  logic [6:0] src4;
  logic [7:0] src5;
  logic mm_go, tick_go;
  int failures, comparisons, cycles;

  ipe_core uut (.ref_clk(ref_clk), .reset(reset), .clk_en(1'b1),
    .avm_req(req), .avm_readdata(rdata), .avm_readdatavalid(rvalid),
    .avm_waitrequest(wreq), .pin_in(pin_in), .portb_hi(portb_hi),
    .evt(evt), .irq_high(irq_high), .irq_low(irq_low),
    .wake_core(wake_core));
  ipe_src_model src (.ref_clk(ref_clk), .reset(reset), .pin_lvl(pin_lvl),
    .pb_lvl(pb_lvl), .src4_lvl(src4), .src5_lvl(src5), .mm_go(mm_go),
    .tick_go(tick_go),
    .pin_in(pin_in), .portb_hi(portb_hi), .evt(evt));

  // Clock, 5 ns period
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  task automatic test_done();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One Avalon access, held until waitrequest is seen low at an edge
  task automatic bus(input logic [3:0] a, input logic wr,
                     input logic [7:0] d, output logic [31:0] q);
    @(posedge ref_clk);
    req <= '{address: a, read: !wr, write: wr, writedata: {24'h0, d},
             byteenable: 4'hf};
    do @(posedge ref_clk); while (wreq !== 1'b0);
    q = rdata;
    check("readdatavalid", {31'h0, !wr}, {31'h0, rvalid});
    req <= '0;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(a, 1'b1, d, q);
  endtask

  task automatic rdc(input string n, input logic [3:0] a,
                     input logic [7:0] e);
    logic [31:0] q;
    bus(a, 1'b0, 8'h00, q);
    check(n, {24'h0, e}, q);
  endtask

  task automatic hold(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // Hang guard, far above the few hundred cycles the tests need
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 4000) begin
      failures++;
      $display("timeout");
      test_done();
    end
  end

  initial begin
    reset = 1'b1;
    req = '0;
    pin_lvl = 4'h0;
    pb_lvl = 4'h0;
    src4 = 7'h00;
    src5 = 8'h00;
    mm_go = 1'b0;
    tick_go = 1'b0;
    hold(6);
    reset <= 1'b0;
    // Reset values, read-only bits, unmapped place
    rdc("prio4", IDX_PRIO4, 8'hf7);
    rdc("prio5", IDX_PRIO5, 8'hff);
    rdc("rcause", IDX_RCAUSE, 8'h7c);
    rdc("chg_en", IDX_CHG_EN, 8'h00);
    rdc("unmapped", 4'hb, 8'h00);
    wr(IDX_PRIO4, 8'hff);
    rdc("prio4 bit3", IDX_PRIO4, 8'hf7);
    wr(IDX_CHG_EN, 8'hff);
    rdc("chg_en low", IDX_CHG_EN, 8'hf0);
    wr(IDX_RCAUSE, 8'h00);
    rdc("rcause ro", IDX_RCAUSE, 8'h0c);
    $display("test registers done");
    // Receive-buffer bits across CAN modes
    wr(IDX_PRIO5, 8'h00);
    rdc("prio5 clr", IDX_PRIO5, 8'h00);
    wr(IDX_PRIO5, 8'hff);
    wr(IDX_MODE, 8'h01);
    rdc("prio5 mode1", IDX_PRIO5, 8'hfe);
    wr(IDX_MODE, 8'h00);
    rdc("prio5 mode0", IDX_PRIO5, 8'hff);
    $display("test can modes done");
    // Mismatch flag set by software, cleared by the reset event
    wr(IDX_RCAUSE, 8'h20);
    rdc("mm set", IDX_RCAUSE, 8'h2c);
    mm_go <= 1'b1;
    hold(4);
    mm_go <= 1'b0;
    rdc("mm clr", IDX_RCAUSE, 8'h0c);
    $display("test mismatch done");
    // Peripheral priority only counts with priority levels on
    wr(IDX_CTL1, 8'hc0);
    src4 <= 7'h40;
    hold(4);
    check("single level", 2'b10, {irq_high, irq_low});
    wr(IDX_PRIO4, 8'h77);
    wr(IDX_RCAUSE, 8'ha0);
    hold(3);
    check("low prio", 2'b01, {irq_high, irq_low});
    src4 <= 7'h00;
    wr(IDX_PRIO5, 8'hfd);
    src5 <= 8'h02;
    hold(3);
    check("can low", 2'b01, {irq_high, irq_low});
    src5 <= 8'h00;
    $display("test priority done");
    // Pin 0 rising, then falling with its enable off
    wr(IDX_CTL1, 8'h90);
    pin_lvl <= 4'h1;
    hold(8);
    check("pin0 high", 3'b101, {irq_high, irq_low, wake_core});
    rdc("pin0 flag", IDX_CTL1, 8'h92);
    wr(IDX_CTL1, 8'h80);
    wr(IDX_CTL2, 8'hbf);
    pin_lvl <= 4'h0;
    hold(8);
    rdc("pin0 fall", IDX_CTL1, 8'h82);
    check("pin0 off", 2'b00, {irq_high, wake_core});
    // Pin 1 on the low level, then cleared before it is enabled again
    wr(IDX_CTL3, 8'h88);
    pin_lvl <= 4'h2;
    hold(8);
    check("pin1 low", 3'b011, {irq_high, irq_low, wake_core});
    rdc("pin1 flag", IDX_CTL3, 8'h89);
    wr(IDX_CTL3, 8'h80);
    wr(IDX_CTL3, 8'h88);
    hold(3);
    check("pin1 cleared", 2'b00, {irq_low, wake_core});
    $display("test pin done");
    // Port B change: unselected pin ignored, selected one flags
    wr(IDX_CHG_EN, 8'h10);
    wr(IDX_CTL1, 8'h88);
    pb_lvl <= 4'h2;
    hold(8);
    rdc("pb masked", IDX_CTL1, 8'h88);
    pb_lvl <= 4'h3;
    hold(8);
    rdc("pb flag", IDX_CTL1, 8'h89);
    check("pb high", 1'b1, irq_high);
    $display("test change done");
    // Timer wrap: 255 ticks leave the flag clear, the 256th sets it
    wr(IDX_CTL1, 8'h00);
    tick_go <= 1'b1;
    hold(255);
    tick_go <= 1'b0;
    hold(3);
    rdc("tmr ff", IDX_TMR_LO, 8'hff);
    rdc("tmr no wrap", IDX_CTL1, 8'h00);
    tick_go <= 1'b1;
    hold(1);
    tick_go <= 1'b0;
    hold(3);
    rdc("tmr wrap", IDX_CTL1, 8'h04);
    // Sixteen-bit mode: a low-byte wrap alone must not set the flag
    wr(IDX_MODE, 8'h04);
    wr(IDX_CTL1, 8'ha0);
    wr(IDX_TMR_LO, 8'hff);
    wr(IDX_TMR_HI, 8'hfe);
    tick_go <= 1'b1;
    hold(1);
    tick_go <= 1'b0;
    hold(3);
    rdc("tmr16 hi", IDX_TMR_HI, 8'hff);
    rdc("tmr16 no wrap", IDX_CTL1, 8'ha0);
    wr(IDX_TMR_LO, 8'hff);
    tick_go <= 1'b1;
    hold(1);
    tick_go <= 1'b0;
    hold(3);
    rdc("tmr16 wrap", IDX_CTL1, 8'ha4);
    check("t0 high", 1'b1, irq_high);
    $display("test timer done");
    test_done();
  end
endmodule
`default_nettype wire
